// *** hdl/fofc_regs.svh ***
// Register offsets, field positions and masks, and reset values for the output float control.
`ifndef FOFC_REGS_SVH
`define FOFC_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define FOFC_OFS_FAST_DISABLE  8'h06
`define FOFC_OFS_FLOAT_FORCE   8'h07
`define FOFC_OFS_WAKE_MISC     8'h08
`define FOFC_OFS_MODULE_CFG    8'h10

// ----------------------------------------------------------------------------
// Field positions and masks
// ----------------------------------------------------------------------------
`define FOFC_BIT_FLOPPY        0
`define FOFC_BIT_PARALLEL      1
`define FOFC_BIT_SERIAL_TWO    2
`define FOFC_BIT_SERIAL_ONE    3
`define FOFC_BIT_KBD_MOUSE     4
`define FOFC_FLOAT_MASK        8'h1f
`define FOFC_DIS_MASK          8'h3f
`define FOFC_CFG_MASK          8'h1f

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define FOFC_RST_FLOAT_FORCE   8'h00
`define FOFC_RST_FAST_DISABLE  8'h00
`define FOFC_RST_WAKE_MISC     8'h00
`define FOFC_RST_MODULE_CFG    8'h00

`endif

// *** hdl/fofc_pkg.sv ***
// Types shared by the output float control files.
package fofc_pkg;
    typedef logic [7:0] fofc_byte_t;
    typedef logic [4:0] fofc_mod_t;
endpackage

// *** hdl/fofc_reg8.sv ***
// One 8-bit software register with write mask and synchronous reset.
`timescale 1ns/10ps
`default_nettype none
module fofc_reg8 #(
    parameter logic [7:0] RST_VAL = 8'h00,
    parameter logic [7:0] MASK    = 8'hff
) (
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_n,
    // Write port
    input  wire logic       i_we,
    input  wire logic [7:0] i_wdata,
    // Stored value
    output logic      [7:0] o_q
);
    logic [7:0] val_q;
    logic [7:0] val_d;

    always_comb begin
        val_d = val_q;
        if (i_we) begin
            val_d = i_wdata & MASK;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            val_q <= RST_VAL;
        end else begin
            val_q <= val_d;
        end
    end

    assign o_q = val_q;
endmodule
`default_nettype wire

// *** hdl/fofc_float_gate.sv ***
// Per-module float decision: forced float when disabled, else own config bit.
`timescale 1ns/10ps
`default_nettype none
module fofc_float_gate (
    // Controls
    input  wire logic [4:0] i_force,
    input  wire logic [4:0] i_disabled,
    input  wire logic [4:0] i_own_cfg,
    // Decision
    output logic      [4:0] o_float
);
    // A force bit only counts for a disabled module; otherwise the module's
    // own float setting decides alone.
    assign o_float = (i_force & i_disabled) | i_own_cfg;
endmodule
`default_nettype wire

// *** hdl/fofc_top.sv ***
// Output float control register bank of the wake control block.
//
// Notes on behaviour
// - One register floats outputs of several modules, bypassing their own config bits.
// - Float force takes effect only while the module is disabled.
// - Float register sits at offset 07h, reachable in every bank.
// - Hardware reset clears the float register to zero.
// - Bit 4 with keyboard/mouse disabled floats all keyboard and mouse outputs.
// - Bit 4 clear: keyboard/mouse float follows its own config bit 0 only.
// - Miscellaneous control register resets to zero.
// - Fast-disable bit set counts as disabled, whatever the activation bit says.
`timescale 1ns/10ps
`default_nettype none
`include "fofc_regs.svh"
module fofc_top (
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst_n,
    // Register port
    input  wire logic [7:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    // Module activation bits, from logic on this clock
    input  wire logic [5:0] i_activate,
    // Float decisions per module
    output logic            o_kbd_mouse_float,
    output logic            o_serial_one_float,
    output logic            o_serial_two_float,
    output logic            o_parallel_float,
    output logic            o_floppy_float,
    // Effective disable per module
    output logic      [5:0] o_mod_disabled
);
    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    fofc_pkg::fofc_byte_t float_force;
    fofc_pkg::fofc_byte_t fast_disable;
    fofc_pkg::fofc_byte_t wake_misc;
    fofc_pkg::fofc_byte_t module_cfg;
    fofc_pkg::fofc_mod_t  dis5;
    fofc_pkg::fofc_mod_t  flt;
    logic [5:0]           dis_all;
    logic [7:0]           rdata_d;
    logic [7:0]           rdata_q;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    // Bank select is not decoded, so the register answers in every bank.
    fofc_reg8 #(.RST_VAL(`FOFC_RST_FLOAT_FORCE), .MASK(`FOFC_FLOAT_MASK)) u_float (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_we      (i_wr && hit(i_addr, `FOFC_OFS_FLOAT_FORCE)),
        .i_wdata   (i_wdata),
        .o_q       (float_force)
    );

    fofc_reg8 #(.RST_VAL(`FOFC_RST_FAST_DISABLE), .MASK(`FOFC_DIS_MASK)) u_fdis (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_we      (i_wr && hit(i_addr, `FOFC_OFS_FAST_DISABLE)),
        .i_wdata   (i_wdata),
        .o_q       (fast_disable)
    );

    fofc_reg8 #(.RST_VAL(`FOFC_RST_WAKE_MISC), .MASK(8'hff)) u_misc (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_we      (i_wr && hit(i_addr, `FOFC_OFS_WAKE_MISC)),
        .i_wdata   (i_wdata),
        .o_q       (wake_misc)
    );

    // Bit n holds the own float config bit 0 of each module's configuration.
    fofc_reg8 #(.RST_VAL(`FOFC_RST_MODULE_CFG), .MASK(`FOFC_CFG_MASK)) u_cfg (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .i_we      (i_wr && hit(i_addr, `FOFC_OFS_MODULE_CFG)),
        .i_wdata   (i_wdata),
        .o_q       (module_cfg)
    );

    // ------------------------------------------------------------------------
    // Disable qualification
    // ------------------------------------------------------------------------
    // Fast-disable bits: 5 keyboard, 4 mouse, 3 serial one, 2 serial two,
    // 1 parallel, 0 floppy. Keyboard/mouse counts disabled when either is.
    assign dis_all = fast_disable[5:0] | ~i_activate;
    assign dis5    = {dis_all[5] | dis_all[4], dis_all[3:0]};

    fofc_float_gate u_gate (
        .i_force    (float_force[4:0]),
        .i_disabled (dis5),
        .i_own_cfg  (module_cfg[4:0]),
        .o_float    (flt)
    );

    assign o_kbd_mouse_float  = flt[`FOFC_BIT_KBD_MOUSE];
    assign o_serial_one_float = flt[`FOFC_BIT_SERIAL_ONE];
    assign o_serial_two_float = flt[`FOFC_BIT_SERIAL_TWO];
    assign o_parallel_float   = flt[`FOFC_BIT_PARALLEL];
    assign o_floppy_float     = flt[`FOFC_BIT_FLOPPY];
    assign o_mod_disabled     = dis_all;

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    always_comb begin
        rdata_d = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                `FOFC_OFS_FAST_DISABLE: rdata_d = fast_disable;
                `FOFC_OFS_FLOAT_FORCE:  rdata_d = float_force;
                `FOFC_OFS_WAKE_MISC:    rdata_d = wake_misc;
                `FOFC_OFS_MODULE_CFG:   rdata_d = module_cfg;
                default:                rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    sequence s_write_force;
        i_wr && (i_addr == `FOFC_OFS_FLOAT_FORCE);
    endsequence

    AST_FORCE_WRITE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        s_write_force |=> (float_force == ($past(i_wdata) & `FOFC_FLOAT_MASK)))
        else $error("float register did not take write");
    AST_ONLY_DISABLED: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (!dis_all[3] && !module_cfg[3]) |-> !o_serial_one_float)
        else $error("enabled module floated");
    AST_READBACK: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (i_rd && i_addr == `FOFC_OFS_FLOAT_FORCE) |=> (o_rdata == $past(float_force)))
        else $error("float register readback wrong");
    AST_RESET_CLEAR: assert property (@(posedge i_clk_sys)
        !i_rst_n |=> (float_force == 8'h00))
        else $error("float register not cleared by reset");
    AST_KBM_FORCE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (float_force[4] && (dis_all[5] || dis_all[4])) |-> o_kbd_mouse_float)
        else $error("keyboard mouse not floated");
    AST_KBM_OWN: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !float_force[4] |-> (o_kbd_mouse_float == module_cfg[4]))
        else $error("keyboard mouse float not from own config");
    AST_MISC_RESET: assert property (@(posedge i_clk_sys)
        !i_rst_n |=> (wake_misc == 8'h00))
        else $error("misc register not cleared by reset");
    AST_FAST_DIS: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        fast_disable[0] |-> o_mod_disabled[0])
        else $error("fast disable ignored");
    AST_FLOPPY_FORCE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (float_force[0] && dis_all[0]) |-> o_floppy_float)
        else $error("floppy not floated");

    // ------------------------------------------------------------------------
    // Register write checks
    // ------------------------------------------------------------------------
    sequence s_write_to(logic [7:0] ofs);
        i_wr && (i_addr == ofs);
    endsequence

    sequence s_read_of(logic [7:0] ofs);
        i_rd && (i_addr == ofs);
    endsequence

    AST_FDIS_WRITE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        s_write_to(`FOFC_OFS_FAST_DISABLE) |=>
            (fast_disable == ($past(i_wdata) & `FOFC_DIS_MASK)))
        else $error("fast disable register did not take write");

    AST_MISC_WRITE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        s_write_to(`FOFC_OFS_WAKE_MISC) |=> (wake_misc == $past(i_wdata)))
        else $error("misc register did not take write");

    AST_CFG_WRITE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        s_write_to(`FOFC_OFS_MODULE_CFG) |=>
            (module_cfg == ($past(i_wdata) & `FOFC_CFG_MASK)))
        else $error("own float config register did not take write");

    AST_FORCE_RSVD: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        float_force[7:5] == 3'h0)
        else $error("reserved float bits not zero");

    // ------------------------------------------------------------------------
    // Read path checks
    // ------------------------------------------------------------------------
    AST_RD_FDIS: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        s_read_of(`FOFC_OFS_FAST_DISABLE) |=> (o_rdata == $past(fast_disable)))
        else $error("fast disable readback wrong");

    AST_RD_MISC: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        s_read_of(`FOFC_OFS_WAKE_MISC) |=> (o_rdata == $past(wake_misc)))
        else $error("misc readback wrong");

    AST_RD_CFG: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        s_read_of(`FOFC_OFS_MODULE_CFG) |=> (o_rdata == $past(module_cfg)))
        else $error("own float config readback wrong");

    // Read data stand for one cycle only, so an idle cycle reads back zero.
    AST_RD_IDLE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !i_rd |=> (o_rdata == 8'h00))
        else $error("read data not zero after idle cycle");

    // ------------------------------------------------------------------------
    // Disable checks
    // ------------------------------------------------------------------------
    AST_FAST_DIS_PAR: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        fast_disable[1] |-> o_mod_disabled[1])
        else $error("parallel fast disable ignored");

    AST_FAST_DIS_SER2: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        fast_disable[2] |-> o_mod_disabled[2])
        else $error("serial two fast disable ignored");

    AST_FAST_DIS_SER1: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        fast_disable[3] |-> o_mod_disabled[3])
        else $error("serial one fast disable ignored");

    AST_FAST_DIS_MS: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        fast_disable[4] |-> o_mod_disabled[4])
        else $error("mouse fast disable ignored");

    AST_FAST_DIS_KBD: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        fast_disable[5] |-> o_mod_disabled[5])
        else $error("keyboard fast disable ignored");

    // ------------------------------------------------------------------------
    // Float checks
    // ------------------------------------------------------------------------
    AST_SER1_FORCE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (float_force[3] && dis_all[3]) |-> o_serial_one_float)
        else $error("serial one not floated");

    AST_SER2_FORCE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (float_force[2] && dis_all[2]) |-> o_serial_two_float)
        else $error("serial two not floated");

    AST_PAR_FORCE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (float_force[1] && dis_all[1]) |-> o_parallel_float)
        else $error("parallel not floated");

    AST_SER1_OWN: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !float_force[3] |-> (o_serial_one_float == module_cfg[3]))
        else $error("serial one float not from own config");

    AST_SER2_OWN: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !float_force[2] |-> (o_serial_two_float == module_cfg[2]))
        else $error("serial two float not from own config");

    AST_PAR_OWN: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !float_force[1] |-> (o_parallel_float == module_cfg[1]))
        else $error("parallel float not from own config");

    AST_FLP_OWN: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        !float_force[0] |-> (o_floppy_float == module_cfg[0]))
        else $error("floppy float not from own config");

    AST_KBM_ENABLED: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (!dis_all[5] && !dis_all[4] && !module_cfg[4]) |-> !o_kbd_mouse_float)
        else $error("enabled keyboard mouse floated");

    AST_SER2_ENABLED: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (!dis_all[2] && !module_cfg[2]) |-> !o_serial_two_float)
        else $error("enabled serial two floated");

    AST_PAR_ENABLED: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (!dis_all[1] && !module_cfg[1]) |-> !o_parallel_float)
        else $error("enabled parallel floated");

    AST_FLP_ENABLED: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (!dis_all[0] && !module_cfg[0]) |-> !o_floppy_float)
        else $error("enabled floppy floated");
endmodule
`default_nettype wire

// *** sim/tb_fast_output_float_control.sv ***
// Self-checking bench for the output float control register bank.
`timescale 1ns/10ps
`default_nettype none
module tb_fast_output_float_control;
    // ------------------------------------------------------------------------
    // Stimulus, observed outputs and reference model
    // ------------------------------------------------------------------------
    logic       i_clk_sys  = 1'b0;
    logic       i_rst_n    = 1'b0;
    logic [7:0] i_addr     = 8'h00;
    logic [7:0] i_wdata    = 8'h00;
    logic       i_wr       = 1'b0;
    logic       i_rd       = 1'b0;
    logic [5:0] i_activate = 6'h3f;
    logic [7:0] o_rdata;
    logic       kbm, s1, s2, par, fdc;
    logic [5:0] o_mod_disabled;
    logic [7:0] fd = 8'h00, ff = 8'h00, cfg = 8'h00;
    int         error_cnt  = 0;
    int         num_checks = 0;

    always #25 i_clk_sys = ~i_clk_sys;

    fofc_top i_dut (
        .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_activate(i_activate),
        .o_kbd_mouse_float(kbm), .o_serial_one_float(s1), .o_serial_two_float(s2),
        .o_parallel_float(par), .o_floppy_float(fdc), .o_mod_disabled(o_mod_disabled)
    );

    // ------------------------------------------------------------------------
    // Bus cycles and comparisons
    // ------------------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_wr    <= 1'b1;
        i_addr  <= a;
        i_wdata <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
        #1;
        if (a == 8'h06) fd = d & 8'h3f;
        if (a == 8'h07) ff = d & 8'h1f;
        if (a == 8'h10) cfg = d & 8'h1f;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk_sys);
        i_rd   <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        chk("rdata", exp, o_rdata);
    endtask

    task automatic set_act(input logic [5:0] a);
        @(posedge i_clk_sys);
        i_activate <= a;
        #1;
    endtask

    task automatic check_out();
        logic [5:0] dis;
        logic [4:0] exp;
        dis = fd[5:0] | ~i_activate;
        exp = (ff[4:0] & {dis[5] | dis[4], dis[3:0]}) | cfg[4:0];
        chk("disabled", {2'b00, dis}, {2'b00, o_mod_disabled});
        chk("float", {3'b000, exp}, {3'b000, kbm, s1, s2, par, fdc});
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic test_reset();
        #1;
        check_out();
        rd(8'h07, 8'h00);
        rd(8'h08, 8'h00);
        rd(8'h06, 8'h00);
        rd(8'h10, 8'h00);
    endtask

    task automatic test_regs();
        put(8'h07, 8'hff);
        rd(8'h07, 8'h1f);
        rd(8'h07, 8'h1f);
        put(8'h08, 8'ha5);
        rd(8'h08, 8'ha5);
        put(8'h20, 8'h5a);
        rd(8'h20, 8'h00);
        rd(8'h07, 8'h1f);
    endtask

    task automatic test_gate();
        set_act(6'h3f);
        check_out();
        for (int i = 0; i < 6; i++) begin
            set_act(~(6'h01 << i));
            check_out();
        end
        set_act(6'h00);
        check_out();
        set_act(6'h3f);
        for (int i = 0; i < 6; i++) begin
            put(8'h06, 8'h01 << i);
            check_out();
        end
        put(8'h06, 8'h00);
        check_out();
    endtask

    // With the force clear, each float follows only the module's own setting.
    task automatic test_own();
        put(8'h06, 8'h3f);
        put(8'h07, 8'h00);
        check_out();
        for (int i = 0; i < 5; i++) begin
            put(8'h10, 8'h01 << i);
            check_out();
        end
        put(8'h07, 8'h1f);
        check_out();
    endtask

    // ------------------------------------------------------------------------
    // Verdict, main sequence and watchdog
    // ------------------------------------------------------------------------
    task automatic finish_test();
        $display("Checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        test_reset();
        test_regs();
        test_gate();
        test_own();
        finish_test();
    end

    initial begin
        repeat (2000) @(posedge i_clk_sys);
        error_cnt++;
        finish_test();
    end
endmodule
`default_nettype wire
